/* rtl/ppl_consts.svh */
`ifndef PPL_CONSTS_SVH
`define PPL_CONSTS_SVH

// Programmer commands
`define PPL_CMD_CHIP_ERASE 8'h80
`define PPL_CMD_WR_FUSE_LO 8'h40
`define PPL_CMD_WR_LOCK    8'h20
`define PPL_CMD_WR_FLASH   8'h10
`define PPL_CMD_WR_EEPROM  8'h11
`define PPL_CMD_RD_FLASH   8'h02
`define PPL_CMD_RD_EEPROM  8'h03

// Action select codes
`define PPL_XA_ADDR 2'h0
`define PPL_XA_DATA 2'h1
`define PPL_XA_CMD  2'h2

// Lock byte field positions
`define PPL_POS_MEM_LO  0
`define PPL_POS_MEM_HI  1
`define PPL_POS_APP_LO  2
`define PPL_POS_APP_HI  3
`define PPL_POS_BOOT_LO 4
`define PPL_POS_BOOT_HI 5

// Reset values
`define PPL_LOCK_RST   6'h3f
`define PPL_LOCK_UNUSE 2'h3
`define PPL_FUSE_RST   8'hff

// Write busy time and its cycle count
`define PPL_T_WR_NS  4000
`define PPL_CLK_MHZ  250
`define PPL_WR_CYC   ((`PPL_T_WR_NS * `PPL_CLK_MHZ + 999) / 1000)

`endif

/* rtl/ppl_pkg.sv */
package ppl_pkg;

  // Memory lock protection modes
  typedef enum logic [1:0] {
    PPL_ML1,
    PPL_ML2,
    PPL_ML3
  } ppl_mlock_e;

  // Application section boot lock modes
  typedef enum logic [1:0] {
    PPL_AL1,
    PPL_AL2,
    PPL_AL3,
    PPL_AL4
  } ppl_alock_e;

  // Sequencer states
  typedef enum logic {
    PPL_IDLE,
    PPL_BUSY
  } ppl_state_e;

  // Whole state of the access logic
  typedef struct packed {
    ppl_state_e  st;
    logic [7:0]  cmd;
    logic [15:0] addr;
    logic [7:0]  dlo;
    logic [7:0]  dhi;
    logic [5:0]  lock;
    logic [7:0]  fuse;
    logic [15:0] cnt;
    logic        wr_d;
    logic        we_f;
    logic        we_e;
    logic [7:0]  dout;
    logic        doe;
  } ppl_state_s;

endpackage

/* rtl/ppl_mem.sv */
`timescale 1ns/1ps
// Single port memory with registered read data
module ppl_mem #(
  parameter int DW = 8,
  parameter int AW = 9
) (
  // Clock
  input  wire logic          mclk,
  // Access
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata_r
);

  logic [DW-1:0] mem [0:(1<<AW)-1]; // Storage array

  // Write and registered read
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata_r <= mem[addr];
  end

endmodule // ppl_mem

/* rtl/ppl_access.sv */
// Functional notes
// (RQ1) Six lock bits, only chip erase sets them; here reset also loads all six to ones
// (RQ2) Boot bits 5:2, memory bits 1:0, top ones
// (RQ3) Memory mode 1 imposes no restrictions
// (RQ4) Mode 2 blocks programming and fuses, verify allowed
// (RQ5) Mode 3 blocks programming, verification and fuses
// (RQ6) App mode 1 leaves self-write and loads free
// (RQ7) App mode 2 blocks self-writes to application
// (RQ8) App mode 3 blocks self-writes and boot loads
// (RQ9) App mode 4 blocks only boot loads
// (RQ10) Modes 3/4 suppress interrupts in application code
// (RQ11) Flash read: command, address high, address low
// (RQ12) Flash read byte chosen by byte select one
// (RQ13) EEPROM byte presented until output enable rises
// (RQ14) Fuse data: zero programs, one erases
// (RQ15) Ready/busy low until fuse write completes
// (RQ16) Forbidden commands ignored, memories unchanged
`timescale 1ns/1ps
`include "ppl_consts.svh"
module ppl_access #(
  parameter int FLASH_AW = 13,
  parameter int EE_AW    = 9,
  parameter int WR_CYC   = `PPL_WR_CYC
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       arst_n,
  // Parallel programming port
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  input  wire logic       load_strobe,
  input  wire logic       action_select_hi,
  input  wire logic       action_select_lo,
  input  wire logic       byte_select_one,
  input  wire logic       byte_select_two,
  input  wire logic       wr_n,
  input  wire logic       oe_n,
  output logic            ready_busy,
  // Self-programming checks
  input  wire logic       self_program_write,
  input  wire logic       program_memory_load,
  input  wire logic       target_app,
  input  wire logic       exec_in_boot,
  input  wire logic       ivec_in_boot,
  output logic            spm_grant,
  output logic            lpm_grant,
  output logic            irq_block,
  // Nonvolatile state
  output logic      [7:0] lock_byte,
  output logic      [7:0] fuse_low
);

  ppl_pkg::ppl_state_s s_r;       // Registered state
  ppl_pkg::ppl_state_s s_nxt;     // Next state
  ppl_pkg::ppl_mlock_e mm;        // Memory lock mode
  ppl_pkg::ppl_alock_e am;        // Application lock mode
  logic [15:0]         f_rd;      // Flash read word
  logic [7:0]          e_rd;      // EEPROM read byte
  logic [7:0]          f_sel;     // Flash byte chosen for output
  logic                prog_ok;   // Programming and fuse writes allowed
  logic                verify_ok; // Reading back allowed
  logic                wr_fall;   // Write strobe falling edge
  logic                bs_zero;   // Both byte selects low

  // Memory lock decode; unlisted code taken as most restrictive
  function automatic ppl_pkg::ppl_mlock_e mem_mode(input logic [1:0] b);
    case (b)
      2'b11:   mem_mode = ppl_pkg::PPL_ML1;
      2'b10:   mem_mode = ppl_pkg::PPL_ML2;
      default: mem_mode = ppl_pkg::PPL_ML3;
    endcase
  endfunction

  // Application lock decode
  function automatic ppl_pkg::ppl_alock_e app_mode(input logic [1:0] b);
    case (b)
      2'b11:   app_mode = ppl_pkg::PPL_AL1;
      2'b10:   app_mode = ppl_pkg::PPL_AL2;
      2'b00:   app_mode = ppl_pkg::PPL_AL3;
      default: app_mode = ppl_pkg::PPL_AL4;
    endcase
  endfunction

  // Lock mode decodes
  always_comb begin
    mm        = mem_mode(s_r.lock[`PPL_POS_MEM_HI:`PPL_POS_MEM_LO]);
    am        = app_mode(s_r.lock[`PPL_POS_APP_HI:`PPL_POS_APP_LO]);
    prog_ok   = (mm == ppl_pkg::PPL_ML1);             // [RQ3] [RQ4]
    verify_ok = (mm != ppl_pkg::PPL_ML3);             // [RQ5]
    wr_fall   = s_r.wr_d & ~wr_n;
    bs_zero   = ~byte_select_one & ~byte_select_two;
    f_sel     = byte_select_one ? f_rd[15:8] : f_rd[7:0]; // [RQ12]
  end

  // Program flash storage
  ppl_mem #(.DW(16), .AW(FLASH_AW)) u_flash (
    .mclk    (mclk),
    .we      (s_r.we_f),
    .addr    (s_r.addr[FLASH_AW-1:0]),
    .wdata   ({s_r.dhi, s_r.dlo}),
    .rdata_r (f_rd)
  );

  // Data EEPROM storage
  ppl_mem #(.DW(8), .AW(EE_AW)) u_eeprom (
    .mclk    (mclk),
    .we      (s_r.we_e),
    .addr    (s_r.addr[EE_AW-1:0]),
    .wdata   (s_r.dlo),
    .rdata_r (e_rd)
  );

  // Next state
  always_comb begin
    s_nxt      = s_r;
    s_nxt.wr_d = wr_n;
    s_nxt.we_f = 1'b0;
    s_nxt.we_e = 1'b0;
    case (s_r.st)
      ppl_pkg::PPL_IDLE: begin
        // Loads of address, data and command
        if (load_strobe) begin
          case ({action_select_hi, action_select_lo})
            `PPL_XA_ADDR: begin                        // [RQ11]
              if (byte_select_one) begin
                s_nxt.addr[15:8] = data_in;
              end else begin
                s_nxt.addr[7:0] = data_in;
              end
            end
            `PPL_XA_DATA: begin
              if (byte_select_one) begin
                s_nxt.dhi = data_in;
              end else begin
                s_nxt.dlo = data_in;
              end
            end
            `PPL_XA_CMD: s_nxt.cmd = data_in;
            default: ;                                 // No action
          endcase
        end
        // Write pulse starts a timed operation if allowed
        if (wr_fall && bs_zero) begin
          case (s_r.cmd)
            `PPL_CMD_WR_FUSE_LO: begin
              if (prog_ok) begin                       // [RQ4] [RQ16]
                s_nxt.st  = ppl_pkg::PPL_BUSY;         // [RQ15]
                s_nxt.cnt = WR_CYC[15:0];
              end
            end
            `PPL_CMD_WR_FLASH: begin
              if (prog_ok) begin                       // [RQ16]
                s_nxt.we_f = 1'b1;
                s_nxt.st   = ppl_pkg::PPL_BUSY;
                s_nxt.cnt  = WR_CYC[15:0];
              end
            end
            `PPL_CMD_WR_EEPROM: begin
              if (prog_ok) begin                       // [RQ16]
                s_nxt.we_e = 1'b1;
                s_nxt.st   = ppl_pkg::PPL_BUSY;
                s_nxt.cnt  = WR_CYC[15:0];
              end
            end
            `PPL_CMD_WR_LOCK, `PPL_CMD_CHIP_ERASE: begin
              s_nxt.st  = ppl_pkg::PPL_BUSY;
              s_nxt.cnt = WR_CYC[15:0];
            end
            default: ;                                 // Not a write
          endcase
        end
      end
      ppl_pkg::PPL_BUSY: begin
        // Count the write time, then commit
        s_nxt.cnt = s_r.cnt - 16'h0001;
        if (s_r.cnt <= 16'h0001) begin
          s_nxt.st = ppl_pkg::PPL_IDLE;                // [RQ15]
          case (s_r.cmd)
            `PPL_CMD_WR_FUSE_LO: s_nxt.fuse = s_r.dlo; // [RQ14]
            `PPL_CMD_WR_LOCK: s_nxt.lock = s_r.lock & s_r.dlo[5:0]; // [RQ1]
            `PPL_CMD_CHIP_ERASE: s_nxt.lock = `PPL_LOCK_RST; // [RQ1]
            default: ;
          endcase
        end
      end
      default: s_nxt.st = ppl_pkg::PPL_IDLE;
    endcase
    // Read back while output enable is low
    s_nxt.doe  = 1'b0;
    s_nxt.dout = s_r.dout;
    if (!oe_n && verify_ok && s_r.st == ppl_pkg::PPL_IDLE) begin
      if (s_r.cmd == `PPL_CMD_RD_FLASH) begin
        s_nxt.doe  = 1'b1;                             // [RQ12]
        s_nxt.dout = f_sel;
      end else if (s_r.cmd == `PPL_CMD_RD_EEPROM) begin
        s_nxt.doe  = 1'b1;                             // [RQ13]
        s_nxt.dout = e_rd;
      end
    end
  end

  // State register
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_r      <= '0;
      s_r.st   <= ppl_pkg::PPL_IDLE;
      s_r.lock <= `PPL_LOCK_RST;                       // [RQ1]
      s_r.fuse <= `PPL_FUSE_RST;
      s_r.wr_d <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs and self-programming gates
  always_comb begin
    data_out   = s_r.dout;
    data_oe    = s_r.doe;
    ready_busy = (s_r.st == ppl_pkg::PPL_IDLE);
    lock_byte  = {`PPL_LOCK_UNUSE, s_r.lock};          // [RQ2]
    fuse_low   = s_r.fuse;
    spm_grant  = self_program_write &                  // [RQ6] [RQ7]
                 (~target_app | am == ppl_pkg::PPL_AL1 |
                  am == ppl_pkg::PPL_AL4);             // [RQ8] [RQ9]
    lpm_grant  = program_memory_load &                 // [RQ6]
                 (~(target_app & exec_in_boot) |
                  am == ppl_pkg::PPL_AL1 |
                  am == ppl_pkg::PPL_AL2);             // [RQ8] [RQ9]
    irq_block  = ivec_in_boot & ~exec_in_boot &
                 (am == ppl_pkg::PPL_AL3 | am == ppl_pkg::PPL_AL4); // [RQ10]
  end

  // Checks
  AST_LOCK_RISE_ERASE: assert property (@(posedge mclk) // [RQ1]
    disable iff (!arst_n)
    ((s_r.lock & ~$past(s_r.lock)) != 6'h00) |->
    ($past(s_r.cmd) == `PPL_CMD_CHIP_ERASE))
    else $error("Lock bit erased without chip erase");
  AST_LOCK_LAYOUT: assert property (@(posedge mclk) // [RQ2]
    disable iff (!arst_n)
    $changed(s_r.lock) |=>
    lock_byte == {2'b11, $past(s_r.lock, 1)} && lock_byte[7:6] == 2'b11)
    else $error("Lock byte layout wrong");
  AST_FUSE_ACCEPT: assert property (@(posedge mclk) // [RQ3]
    disable iff (!arst_n)
    (ready_busy && wr_fall && bs_zero && s_r.cmd == `PPL_CMD_WR_FUSE_LO &&
     s_r.lock[1:0] == 2'b11) |=> !ready_busy)
    else $error("Fuse write refused in open mode");
  AST_FUSE_REFUSE: assert property (@(posedge mclk) // [RQ4] [RQ16]
    disable iff (!arst_n)
    (ready_busy && s_r.cmd == `PPL_CMD_WR_FUSE_LO && s_r.lock[1:0] != 2'b11)
    |=> ready_busy && $stable(fuse_low))
    else $error("Fuse write taken while locked");
  AST_NO_VERIFY: assert property (@(posedge mclk) // [RQ5]
    disable iff (!arst_n)
    data_oe |-> $past(s_r.lock[1:0]) != 2'b00)
    else $error("Read back in lock mode 3");
  AST_SPM_OPEN: assert property (@(posedge mclk) // [RQ6]
    disable iff (!arst_n)
    (s_r.lock[3:2] == 2'b11) |-> (spm_grant == self_program_write &&
     lpm_grant == program_memory_load))
    else $error("Open mode restricted access");
  AST_SPM_BLOCK: assert property (@(posedge mclk) // [RQ7] [RQ8]
    disable iff (!arst_n)
    (self_program_write && target_app && !s_r.lock[2]) |-> !spm_grant)
    else $error("Self-write reached locked application");
  AST_LPM_BLOCK: assert property (@(posedge mclk) // [RQ8] [RQ9]
    disable iff (!arst_n)
    (program_memory_load && target_app && exec_in_boot && !s_r.lock[3])
    |-> !lpm_grant)
    else $error("Boot load read locked application");
  AST_SPM_MODE4: assert property (@(posedge mclk) // [RQ9]
    disable iff (!arst_n)
    (s_r.lock[3:2] == 2'b01 && self_program_write) |-> spm_grant)
    else $error("Self-write blocked in mode 4");
  AST_IRQ_BLOCK: assert property (@(posedge mclk) // [RQ10]
    disable iff (!arst_n)
    irq_block |-> (ivec_in_boot && !exec_in_boot && !s_r.lock[3]))
    else $error("Interrupt suppressed wrongly");
  AST_READ_BYTE: assert property (@(posedge mclk) // [RQ12]
    disable iff (!arst_n)
    (!oe_n && ready_busy && verify_ok && s_r.cmd == `PPL_CMD_RD_FLASH)
    |=> data_oe && data_out == $past(f_sel))
    else $error("Wrong flash byte presented");
  AST_OE_RELEASE: assert property (@(posedge mclk) // [RQ13]
    disable iff (!arst_n)
    $rose(oe_n) |=> !data_oe)
    else $error("Data held after output enable rose");
  // Busy span is tracked on the down counter, not a long delay range
  AST_BUSY_LEN: assert property (@(posedge mclk) // [RQ15]
    disable iff (!arst_n)
    $fell(ready_busy) |-> s_r.cnt == WR_CYC[15:0])
    else $error("Busy time out of range");
  AST_BUSY_HOLD: assert property (@(posedge mclk) // [RQ15]
    disable iff (!arst_n)
    (!ready_busy && s_r.cnt > 16'h0001) |=>
    (!ready_busy && s_r.cnt == $past(s_r.cnt) - 16'h0001))
    else $error("Busy ended early or count stalled");
  AST_BUSY_DONE: assert property (@(posedge mclk) // [RQ15]
    disable iff (!arst_n)
    (!ready_busy && s_r.cnt <= 16'h0001) |=> ready_busy)
    else $error("Busy held past write time");

endmodule // ppl_access

/* verif/ppl_prog_model.sv */
`timescale 1ns/1ps
// Parallel programmer model, drives at falling edges
module ppl_prog_model (
  // Clock and status
  input  wire logic       mclk,
  input  wire logic       ready_busy,
  // Port towards the device
  output logic      [7:0] data_in,
  output logic            load_strobe,
  output logic            action_select_hi,
  output logic            action_select_lo,
  output logic            byte_select_one,
  output logic            byte_select_two,
  output logic            wr_n,
  output logic            oe_n
);
  // Idle levels from time zero
  initial begin
    data_in = 8'h00;
    load_strobe = 1'b0;
    {action_select_hi, action_select_lo} = 2'h3;
    byte_select_one = 1'b0;
    byte_select_two = 1'b0;
    wr_n = 1'b1;
    oe_n = 1'b1;
  end
  // One load; released bus shows inverse
  task automatic ld(input logic [1:0] xa, input logic bs,
                    input logic [7:0] d);
    @(negedge mclk);
    {action_select_hi, action_select_lo} = xa;
    byte_select_one = bs;
    data_in = d;
    load_strobe = 1'b1;
    @(negedge mclk);
    load_strobe = 1'b0;
    data_in = ~d;
  endtask
  // Command, then high and low address
  task automatic cmd_addr(input logic [7:0] c, input logic [15:0] a);
    ld(2'h2, 1'b0, c);
    ld(2'h0, 1'b1, a[15:8]);
    ld(2'h0, 1'b0, a[7:0]);
  endtask
  // Data word, low byte first
  task automatic dat(input logic [15:0] w);
    ld(2'h1, 1'b0, w[7:0]);
    ld(2'h1, 1'b1, w[15:8]);
  endtask
  // Write pulse, then count busy cycles
  task automatic wr(output int n);
    n = 0;
    @(negedge mclk);
    byte_select_one = 1'b0;
    byte_select_two = 1'b0;
    wr_n = 1'b0;
    @(negedge mclk);
    wr_n = 1'b1;
    // Busy already shows here, registered at the rising edge that takes the pulse
    if (ready_busy !== 1'b1) n++;
    repeat (12) begin
      @(negedge mclk);
      if (ready_busy !== 1'b1) n++;
    end
  endtask
  // Output enable and byte select, caller at a falling edge
  task automatic oe(input logic o, input logic bs);
    oe_n = o;
    byte_select_one = bs;
  endtask
endmodule // ppl_prog_model

/* verif/parallel_program_lock_access_tb.sv */
`timescale 1ns/1ps
`include "ppl_consts.svh"
module parallel_program_lock_access_tb;
  localparam int WRC = 4; // Shortened write time
  logic        mclk, arst_n, load_strobe, wr_n, oe_n, data_oe;
  logic        action_select_hi, action_select_lo, ready_busy;
  logic        byte_select_one, byte_select_two, target_app;
  logic        self_program_write, program_memory_load;
  logic        exec_in_boot, ivec_in_boot, spm_grant, lpm_grant;
  logic        irq_block, ok;
  logic [7:0]  data_in, data_out, lock_byte, fuse_low, fx;
  logic [5:0]  lk;
  logic [15:0] fw, nw;
  logic [31:0] seed;
  int          miscompares = 0, checked = 0, n;
  // Device under test
  ppl_access #(.WR_CYC(WRC)) u_dut (.mclk, .arst_n, .data_in,
    .data_out, .data_oe, .load_strobe, .action_select_hi,
    .action_select_lo, .byte_select_one, .byte_select_two, .wr_n,
    .oe_n, .ready_busy, .self_program_write, .program_memory_load,
    .target_app, .exec_in_boot, .ivec_in_boot, .spm_grant,
    .lpm_grant, .irq_block, .lock_byte, .fuse_low);
  // Programmer on the far side
  ppl_prog_model u_prog (.mclk, .ready_busy, .data_in, .load_strobe,
    .action_select_hi, .action_select_lo, .byte_select_one,
    .byte_select_two, .wr_n, .oe_n);
  // Clock, 4 ns
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Pseudo random source
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Compare and count
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // Read one location, check bytes and release
  task automatic rd(input logic [7:0] c, input logic [15:0] a,
                    input logic [15:0] w, input logic fl,
                    input logic en);
    u_prog.cmd_addr(c, a);
    repeat (3) @(negedge mclk);
    u_prog.oe(1'b0, 1'b0);
    @(negedge mclk);
    chk("data_oe", 16'(en), 16'(data_oe));
    if (en) chk("rd_lo", 16'(w[7:0]), 16'(data_out));
    if (fl) begin
      u_prog.oe(1'b0, 1'b1);
      @(negedge mclk);
      if (en) chk("rd_hi", 16'(w[15:8]), 16'(data_out));
    end
    u_prog.oe(1'b1, 1'b0);
    repeat (2) @(negedge mclk);
    chk("oe_off", 16'h0, 16'(data_oe));
  endtask
  // Ending and verdict
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog against hangs
  initial begin
    repeat (6000) @(posedge mclk);
    miscompares++;
    wrap_up();
  end
  // Main sequence
  initial begin
    arst_n = 1'b0;
    {self_program_write, program_memory_load} = 2'h0;
    {target_app, exec_in_boot, ivec_in_boot} = 3'h0;
    seed = 32'hffb1;
    repeat (16) @(negedge mclk);
    chk("lock_rst", 16'hff, 16'(lock_byte));
    chk("fuse_rst", 16'hff, 16'(fuse_low));
    chk("rdy_rst", 16'h1, 16'(ready_busy));
    arst_n = 1'b1;
    $display("test reset end");
    // Flash word and EEPROM byte, written then read
    seed = lfsr(seed);
    fw = seed[15:0];
    fx = 8'hff;
    u_prog.cmd_addr(`PPL_CMD_WR_FLASH, 16'h0123);
    u_prog.dat(fw);
    u_prog.wr(n);
    chk("busy_cyc", 16'(WRC), 16'(n));
    rd(`PPL_CMD_RD_FLASH, 16'h0123, fw, 1'b1, 1'b1);
    u_prog.cmd_addr(`PPL_CMD_WR_EEPROM, 16'h01a5);
    u_prog.dat(~fw);
    u_prog.wr(n);
    rd(`PPL_CMD_RD_EEPROM, 16'h01a5, ~fw, 1'b0, 1'b1);
    $display("test memories end");
    // Four lock settings: gates, fuse, flash, erase
    for (int i = 0; i < 4; i++) begin
      lk = {2'h3, i[1:0], 2'(3 - i)};
      ok = (lk[1:0] == 2'h3);
      u_prog.cmd_addr(`PPL_CMD_WR_LOCK, 16'h0000);
      u_prog.dat({10'h3, lk});
      u_prog.wr(n);
      chk("lock_byte", {8'h00, 2'h3, lk}, 16'(lock_byte));
      for (int c = 0; c < 32; c++) begin
        @(negedge mclk);
        {self_program_write, program_memory_load} = 2'(c >> 3);
        {target_app, exec_in_boot, ivec_in_boot} = 3'(c);
        #1;
        chk("spm", 16'(self_program_write & ~(target_app & ~lk[2])),
            16'(spm_grant));
        chk("lpm", 16'(program_memory_load &
            ~(target_app & exec_in_boot & ~lk[3])),
            16'(lpm_grant));
        chk("irq", 16'(~lk[3] & ivec_in_boot & ~exec_in_boot),
            16'(irq_block));
      end
      seed = lfsr(seed);
      u_prog.cmd_addr(`PPL_CMD_WR_FUSE_LO, 16'h0000);
      u_prog.ld(2'h1, 1'b0, seed[7:0]);
      u_prog.wr(n);
      chk("fuse_busy", ok ? 16'(WRC) : 16'h0, 16'(n));
      if (ok) fx = seed[7:0];
      chk("fuse_low", 16'(fx), 16'(fuse_low));
      nw = seed[31:16];
      u_prog.cmd_addr(`PPL_CMD_WR_FLASH, 16'h0123);
      u_prog.dat(nw);
      u_prog.wr(n);
      if (ok) fw = nw;
      chk("fl_busy", ok ? 16'(WRC) : 16'h0, 16'(n));
      rd(`PPL_CMD_RD_FLASH, 16'h0123, fw, 1'b1, lk[1]);
      u_prog.cmd_addr(`PPL_CMD_CHIP_ERASE, 16'h0000);
      u_prog.wr(n);
      chk("lock_erase", 16'hff, 16'(lock_byte));
      $display("test lock setting %0d end", i);
    end
    wrap_up();
  end
endmodule // parallel_program_lock_access_tb
